// ### core/xbus_defs.svh
// constants for the host-cycle decoder and auxiliary bus port
// assumes inclusion by bare name from the design file
`ifndef XBUS_DEFS_SVH
`define XBUS_DEFS_SVH

// serial host bus nibble codes
`define LPC_START      4'h0
`define LPC_IO_READ    4'h2
`define LPC_IO_WRITE   4'h3
`define LPC_SYNC_READY 4'h0
`define LPC_SYNC_LONG  4'h6
`define LPC_TURN       4'hf
`define LPC_ADDR_NIBS  2'h3
`define LPC_DATA_NIBS  2'h1
`define LPC_TAR_NIBS   2'h1

// decoded host i/o addresses
`define ADDR_POST      16'h0080
`define ADDR_RTC_INDEX 16'h0070
`define ADDR_RTC_DATA  16'h0071
`define ADDR_KBC_DATA  16'h0060
`define ADDR_KBC_CMD   16'h0064
`define ADDR_MC_DATA   16'h0062
`define ADDR_MC_CMD    16'h0066

// global option register
`define GOR_RESET      8'h00
`define GOR_KB_DIS_BIT 7

// strobe timing
`define CLK_PERIOD_NS  5
`define STROBE_NS      120

`endif

// ### core/xbus_pkg.sv
// types shared by the decoder and its bench
// assumes xbus_defs.svh is on the include path
package xbus_pkg;

  // one decoded chip select per auxiliary-bus peripheral
  typedef struct packed {
    logic post;
    logic rtc;
    logic kbc;
    logic mc;
  } select_type;

  // host i/o cycle as collected off the serial bus
  typedef struct packed {
    logic        is_write;
    logic [15:0] addr;
    logic [7:0]  data;
  } cycle_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CYCTYPE,
    ST_ADDR,
    ST_WDATA,
    ST_TAR_HOST,
    ST_XFER,
    ST_SYNC,
    ST_RDATA,
    ST_TAR_DEV
  } lpc_state_type;

endpackage

// ### core/xbus_chip_select_decode.sv
// host i/o cycle decoder with auxiliary 8-bit peripheral bus port
// assumes a 4-bit serial host bus on core_clk_in; inputs synchronous to it
//
// Function
// - post-code select asserts for i/o writes to 0x80 only, never reads
// - rtc select asserts for host i/o cycles to 0x70 or 0x71
// - keyboard controller select asserts for i/o cycles to 0x60 or 0x64
// - mobile controller select asserts for i/o cycles to 0x62 or 0x66
// - keyboard and mobile selects only when enable strap sampled low on the first edge after reset
// - strap pulled low during reset, latched into option bit 7; high disables keyboard
// - reads pulse the read strobe and capture the peripheral byte
// - writes drive the byte and pulse the write strobe; slave latches it
// - 8-bit auxiliary data bus driven by this block only during writes
// - keyboard interrupt inputs 1 and 12 forwarded to the host only while the strap enables the keyboard
// - host cycles arrive over a 4-bit-per-clock serial bus
`timescale 1ns/100ps
`include "xbus_defs.svh"

module xbus_chip_select_decode
  import xbus_pkg::*;
#(
  parameter int DATA_W    = 8,
  parameter int STROBE_NS = `STROBE_NS
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              lframe_n_in,
  input  wire logic [3:0]        lad_in,
  output logic      [3:0]        lad_out,
  output logic                   lad_oe_out,
  output logic                   post_code_select_n_out,
  output logic                   rtc_select_n_out,
  output logic                   keyboard_ctrl_select_n_out,
  output logic                   mobile_ctrl_select_n_out,
  output logic                   io_read_strobe_n_out,
  output logic                   io_write_strobe_n_out,
  input  wire logic [DATA_W-1:0] aux_data_bus_in,
  output logic      [DATA_W-1:0] aux_data_bus_out,
  output logic                   aux_data_bus_oe_out,
  input  wire logic              keyboard_enable_strap_n_in,
  output logic                   strap_pulldown_out,
  input  wire logic              kbd_irq_line1_in,
  input  wire logic              kbd_irq_line12_in,
  output logic                   host_irq1_out,
  output logic                   host_irq12_out,
  output logic      [7:0]        global_option_register_out
);

  // least strobe width rounds up to whole cycles
  localparam int STROBE_CYC = (STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int CNT_W      = $clog2(STROBE_CYC + 1);
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);

  // the byte path is a fixed two-nibble transfer on the host side
  generate
    if (DATA_W != 8) begin : g_bad_width
      $error("DATA_W must be 8");
    end
    if (STROBE_CYC < 1) begin : g_bad_strobe
      $error("STROBE_NS must give at least one cycle");
    end
  endgenerate

  lpc_state_type    state;
  lpc_state_type    next_state;
  logic [1:0]       nib;
  logic [1:0]       next_nib;
  cycle_type        cyc;
  cycle_type        next_cyc;
  select_type       sel;
  select_type       next_sel;
  logic [CNT_W-1:0] strobe_cnt;
  logic [CNT_W-1:0] next_strobe_cnt;
  logic [7:0]       rd_data;
  logic [7:0]       next_rd_data;
  logic             strap_done;
  logic [7:0]       gor;

  // address decode on the collected cycle
  wire kb_enable = strap_done & ~gor[`GOR_KB_DIS_BIT];
  wire hit_post  = cyc.is_write & (cyc.addr == `ADDR_POST);
  wire hit_rtc   = (cyc.addr == `ADDR_RTC_INDEX) | (cyc.addr == `ADDR_RTC_DATA);
  wire hit_kbc   = kb_enable & ((cyc.addr == `ADDR_KBC_DATA) |
                                (cyc.addr == `ADDR_KBC_CMD));
  wire hit_mc    = kb_enable & ((cyc.addr == `ADDR_MC_DATA) |
                                (cyc.addr == `ADDR_MC_CMD));
  wire hit_any   = hit_post | hit_rtc | hit_kbc | hit_mc;

  wire frame_start = ~lframe_n_in & (lad_in == `LPC_START);
  wire strobe_done = (strobe_cnt == STROBE_LAST);
  wire in_xfer     = (state == ST_XFER);

  // serial host cycle sequencer
  always_comb begin
    next_state      = state;
    next_nib        = nib;
    next_cyc        = cyc;
    next_sel        = sel;
    next_strobe_cnt = strobe_cnt;
    next_rd_data    = rd_data;
    if (~lframe_n_in) begin
      // a frame marker aborts whatever is under way
      next_state = frame_start ? ST_CYCTYPE : ST_IDLE;
      next_sel   = '0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sel = '0;
        end
        ST_CYCTYPE: begin
          next_nib = '0;
          if (lad_in == `LPC_IO_READ) begin
            next_cyc.is_write = 1'b0;
            next_state        = ST_ADDR;
          end else if (lad_in == `LPC_IO_WRITE) begin
            next_cyc.is_write = 1'b1;
            next_state        = ST_ADDR;
          end else begin
            next_state = ST_IDLE; // not an i/o cycle, not ours
          end
        end
        ST_ADDR: begin
          next_cyc.addr = {cyc.addr[11:0], lad_in}; // msb nibble first
          next_nib      = nib + 2'h1;
          if (nib == `LPC_ADDR_NIBS) begin
            next_nib   = '0;
            next_state = cyc.is_write ? ST_WDATA : ST_TAR_HOST;
          end
        end
        ST_WDATA: begin
          next_cyc.data = {lad_in, cyc.data[7:4]}; // low nibble first
          next_nib      = nib + 2'h1;
          if (nib == `LPC_DATA_NIBS) begin
            next_nib   = '0;
            next_state = ST_TAR_HOST;
          end
        end
        ST_TAR_HOST: begin
          next_nib = nib + 2'h1;
          if (nib == 2'h0) begin
            // selects settle before any strobe
            next_sel.post = hit_post;
            next_sel.rtc  = hit_rtc;
            next_sel.kbc  = hit_kbc;
            next_sel.mc   = hit_mc;
          end
          if (nib == `LPC_TAR_NIBS) begin
            next_nib        = '0;
            next_strobe_cnt = '0;
            // unmatched cycles are left unclaimed so the host aborts
            next_state      = hit_any ? ST_XFER : ST_IDLE;
          end
        end
        ST_XFER: begin
          next_strobe_cnt = strobe_cnt + CNT_W'(1);
          if (strobe_done) begin
            if (~cyc.is_write) begin
              next_rd_data = aux_data_bus_in;
            end
            next_state = ST_SYNC;
          end
        end
        ST_SYNC: begin
          next_nib   = '0;
          next_state = cyc.is_write ? ST_TAR_DEV : ST_RDATA;
        end
        ST_RDATA: begin
          next_nib = nib + 2'h1;
          if (nib == `LPC_DATA_NIBS) begin
            next_nib   = '0;
            next_state = ST_TAR_DEV;
          end
        end
        ST_TAR_DEV: begin
          next_state = ST_IDLE;
          next_sel   = '0;
        end
        default: begin
          next_state = ST_IDLE;
          next_sel   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state      <= ST_IDLE;
      nib        <= '0;
      cyc        <= '0;
      sel        <= '0;
      strobe_cnt <= '0;
      rd_data    <= '0;
    end else begin
      state      <= next_state;
      nib        <= next_nib;
      cyc        <= next_cyc;
      sel        <= next_sel;
      strobe_cnt <= next_strobe_cnt;
      rd_data    <= next_rd_data;
    end
  end

  // strap capture one edge after release; the pin cannot be sampled under reset
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_done         <= 1'b0;
      gor                <= `GOR_RESET;
      strap_pulldown_out <= 1'b1;
    end else if (!strap_done) begin
      strap_done               <= 1'b1;
      gor[`GOR_KB_DIS_BIT]     <= keyboard_enable_strap_n_in;
      strap_pulldown_out       <= 1'b0;
    end
  end

  // keyboard interrupts follow the strap like the selects do
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      host_irq1_out  <= 1'b0;
      host_irq12_out <= 1'b0;
    end else begin
      host_irq1_out  <= kbd_irq_line1_in & kb_enable;
      host_irq12_out <= kbd_irq_line12_in & kb_enable;
    end
  end

  // active-low selects straight from their flops
  assign post_code_select_n_out     = ~sel.post;
  assign rtc_select_n_out           = ~sel.rtc;
  assign keyboard_ctrl_select_n_out = ~sel.kbc;
  assign mobile_ctrl_select_n_out   = ~sel.mc;

  // strobes span the whole wait; data held one cycle past the write strobe
  assign io_read_strobe_n_out  = ~(in_xfer & ~cyc.is_write);
  assign io_write_strobe_n_out = ~(in_xfer & cyc.is_write);
  assign aux_data_bus_out      = cyc.data;
  assign aux_data_bus_oe_out   = cyc.is_write & (in_xfer | (state == ST_SYNC));

  assign global_option_register_out = gor;

  // host bus drive: long-wait sync while the strobe runs, then ready
  wire drive_lad = in_xfer | (state == ST_SYNC) | (state == ST_RDATA) |
                   (state == ST_TAR_DEV);
  assign lad_oe_out = drive_lad & lframe_n_in;
  assign lad_out    = in_xfer                ? `LPC_SYNC_LONG :
                      (state == ST_SYNC)     ? `LPC_SYNC_READY :
                      (state == ST_RDATA)    ? (nib[0] ? rd_data[7:4] : rd_data[3:0]) :
                      `LPC_TURN;

endmodule

// ### verification/xbus_cs_assertions.sv
// port-timing checker for the host-cycle decoder
// assumes binding onto the decoder top, strobe length handed on
`timescale 1ns/100ps
module xbus_cs_checker #(
  parameter int STROBE_NS = 120
) (
  input wire logic       core_clk_in,
  input wire logic       rst_b_in,
  input wire logic       lframe_n_in,
  input wire logic [3:0] lad_out,
  input wire logic       lad_oe_out,
  input wire logic       post_code_select_n_out,
  input wire logic       rtc_select_n_out,
  input wire logic       keyboard_ctrl_select_n_out,
  input wire logic       mobile_ctrl_select_n_out,
  input wire logic       io_read_strobe_n_out,
  input wire logic       io_write_strobe_n_out,
  input wire logic       aux_data_bus_oe_out,
  input wire logic       keyboard_enable_strap_n_in,
  input wire logic       strap_pulldown_out,
  input wire logic       kbd_irq_line1_in,
  input wire logic       host_irq1_out,
  input wire logic [7:0] global_option_register_out
);
  // strobe width rounds up to whole 5 ns cycles, as the decoder counts it
  localparam int STR_CYC = (STROBE_NS + 4) / 5;
  logic [7:0] low_cnt;
  wire        idle_strb = io_read_strobe_n_out & io_write_strobe_n_out;
  wire        all_off   = post_code_select_n_out & rtc_select_n_out
                        & keyboard_ctrl_select_n_out & mobile_ctrl_select_n_out;
  // counts strobe-low cycles; a plain repeat cannot follow the parameter
  always_ff @(posedge core_clk_in or negedge rst_b_in)
    if (!rst_b_in) low_cnt <= 8'h00;
    else low_cnt <= idle_strb ? 8'h00 : low_cnt + 8'h01;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_ready; lad_oe_out && lad_out == 4'h0; endsequence
  sequence s_turn; lad_oe_out && lad_out == 4'hf ##1 !lad_oe_out; endsequence
  strobe_len_a: assert property ($rose(idle_strb) |-> low_cnt == STR_CYC)
    else $error("strobe length wrong");
  post_read_a: assert property (!io_read_strobe_n_out |-> post_code_select_n_out)
    else $error("post select on a read");
  wr_tail_a: assert property ($rose(io_write_strobe_n_out) && lframe_n_in |-> s_ready ##1 s_turn)
    else $error("write tail wrong");
  rd_tail_a: assert property ($rose(io_read_strobe_n_out) && lframe_n_in |-> s_ready ##3 s_turn)
    else $error("read tail wrong");
  sel_held_a: assert property (!idle_strb |-> !all_off)
    else $error("strobe without select");
  aux_drive_a: assert property (!idle_strb |-> aux_data_bus_oe_out == !io_write_strobe_n_out)
    else $error("aux drive wrong");
  kb_gate_a: assert property (global_option_register_out[7] |-> !(!keyboard_ctrl_select_n_out || !mobile_ctrl_select_n_out))
    else $error("keyboard select while disabled");
  sel_release_a: assert property ($fell(lad_oe_out) && lframe_n_in |-> all_off)
    else $error("select held after cycle");
  strap_latch_a: assert property ($fell(strap_pulldown_out) |-> global_option_register_out == {$past(keyboard_enable_strap_n_in), 7'h00})
    else $error("strap not latched");
  irq_fwd_a: assert property (!strap_pulldown_out |=> host_irq1_out == ($past(kbd_irq_line1_in) && !$past(global_option_register_out[7])))
    else $error("irq forward wrong");
endmodule
bind xbus_chip_select_decode xbus_cs_checker #(.STROBE_NS(STROBE_NS)) u_chk (.*);

// ### verification/xbus_slave_model.sv
// aux-bus slave model: answers reads, latches writes
// assumes active-low strobes and a byte lane shared with the block
`timescale 1ns/100ps
module xbus_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'hc3
) (
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] drive_out,
  output logic      [7:0] latched_out
);
  // drives RD_BYTE under the read strobe and its inverse at all other times
  assign drive_out = !rd_n_in ? RD_BYTE : ~RD_BYTE;
  // byte taken as the write strobe ends
  always @(posedge wr_n_in) latched_out <= bus_in;
  initial latched_out = 8'h00;
endmodule

// ### verification/xbus_chip_select_decode_test.sv
// bench: host cycles into the decoder, slave model on the aux bus
// assumes 200 MHz clock and a short strobe through STROBE_NS
`timescale 1ns/100ps
module xbus_chip_select_decode_test;
  import xbus_pkg::*;
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [7:0]  d;
    select_type  s;
  } row_type;
  logic        clk, rst_b, fr_n, st_hi, irq1, irq12, lad_oe, pd, aoe, hi1, hi12;
  logic        pst, rtc, kbc, mc, rd_n, wr_n;
  logic [3:0]  lad_h, lad_o;
  logic [7:0]  ao, sd, lat, gor, rdb;
  logic [15:0] hist;
  select_type  seen;
  int          n_fail = 0;
  int          total_checks = 0;
  // nibble lane pulled up when released; strap floats high after reset
  wire [3:0] lad = lad_oe ? lad_o : lad_h;
  wire [7:0] aux = aoe ? ao : sd;
  wire       strap_n = st_hi | !pd;
  row_type rows[10] = '{
    '{1'h1, 16'h0080, 8'ha5, 4'h8}, '{1'h0, 16'h0080, 8'h00, 4'h0},
    '{1'h1, 16'h0070, 8'h5a, 4'h4}, '{1'h0, 16'h0071, 8'h00, 4'h4},
    '{1'h1, 16'h0060, 8'h3c, 4'h2}, '{1'h0, 16'h0064, 8'h00, 4'h2},
    '{1'h1, 16'h0062, 8'h81, 4'h1}, '{1'h0, 16'h0066, 8'h00, 4'h1},
    '{1'h1, 16'h0081, 8'h00, 4'h0}, '{1'h0, 16'h0065, 8'h00, 4'h0}};
  xbus_chip_select_decode #(.STROBE_NS(10)) u_dut (
    .core_clk_in(clk), .rst_b_in(rst_b), .lframe_n_in(fr_n), .lad_in(lad),
    .lad_out(lad_o), .lad_oe_out(lad_oe), .post_code_select_n_out(pst),
    .rtc_select_n_out(rtc), .keyboard_ctrl_select_n_out(kbc),
    .mobile_ctrl_select_n_out(mc), .io_read_strobe_n_out(rd_n),
    .io_write_strobe_n_out(wr_n), .aux_data_bus_in(aux), .aux_data_bus_out(ao),
    .aux_data_bus_oe_out(aoe), .keyboard_enable_strap_n_in(strap_n),
    .strap_pulldown_out(pd), .kbd_irq_line1_in(irq1), .kbd_irq_line12_in(irq12),
    .host_irq1_out(hi1), .host_irq12_out(hi12), .global_option_register_out(gor));
  xbus_slave_model u_slv (.rd_n_in(rd_n), .wr_n_in(wr_n), .bus_in(aux),
    .drive_out(sd), .latched_out(lat));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (e !== g) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic nib(logic [3:0] v, logic f);
    @(negedge clk);
    fr_n = f;
    lad_h = v;
  endtask
  task automatic do_reset(logic hi);
    @(negedge clk);
    rst_b = 1'b0;
    st_hi = hi;
    repeat (20) @(negedge clk);
    chk("rst sel", 4'hf, {pst, rtc, kbc, mc});
    chk("rst pd", 1'b1, pd);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    chk("gor", {hi, 7'h00}, gor);
    chk("pd", 1'b0, pd);
  endtask
  // one host cycle, then watch selects and the device's nibbles
  task automatic cyc(row_type r);
    int k;
    nib(4'h0, 1'b0);
    nib(r.w ? 4'h3 : 4'h2, 1'b1);
    for (k = 3; k >= 0; k--) nib(r.a[4*k+:4], 1'b1);
    if (r.w) nib(r.d[3:0], 1'b1);
    if (r.w) nib(r.d[7:4], 1'b1);
    nib(4'hf, 1'b1);
    nib(4'hf, 1'b1);
    seen = 4'h0;
    hist = 16'h0000;
    for (k = 0; k < 40 && !(hist != 0 && !lad_oe); k++) begin
      seen = seen | ~{pst, rtc, kbc, mc};
      if (lad_oe) hist = {hist[11:0], lad_o};
      @(negedge clk);
    end
    rdb = {hist[7:4], hist[11:8]};
    if (lad_oe) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic irq_t(logic en);
    @(negedge clk);
    irq1 = 1'b1;
    @(negedge clk);
    chk("irq1", en, hi1);
    irq1 = 1'b0;
    irq12 = 1'b1;
    @(negedge clk);
    chk("irq1 off", 1'b0, hi1);
    chk("irq12", en, hi12);
    irq12 = 1'b0;
  endtask
  initial begin
    {rst_b, st_hi, irq1, irq12} = 4'h0;
    fr_n = 1'b1;
    lad_h = 4'hf;
    do_reset(1'b0);
    foreach (rows[i]) begin
      cyc(rows[i]);
      chk("sel", rows[i].s, seen);
      chk("drive", |rows[i].s, |hist);
      if (rows[i].s != 0 && rows[i].w) chk("wbyte", rows[i].d, lat);
      if (rows[i].s != 0 && !rows[i].w) chk("rbyte", 8'hc3, rdb);
      $display("row %0d done", i);
    end
    // abort mid-address, then a fresh start right behind it
    nib(4'h0, 1'b0);
    nib(4'h3, 1'b1);
    nib(4'h0, 1'b1);
    nib(4'hf, 1'b0);
    cyc(rows[2]);
    chk("abort", 4'h4, seen);
    irq_t(1'b1);
    $display("abort and irq done");
    do_reset(1'b1);
    cyc(rows[4]);
    chk("kb off", 4'h0, seen);
    cyc(rows[7]);
    chk("mc off", 4'h0, seen);
    irq_t(1'b0);
    $display("strap high done");
    give_verdict();
  end
endmodule
